/* File: rtl/tmdsc_regs.sv */
// Control register bank of the two-input link switch, with a termination pulse timer.
//
// Functional notes
// R1: Fast enable 0 = standby, 1 = channels active.
// R2: Fast select picks source A or B.
// R3: Side enable 0 opens all low-speed connections.
// R4: Side select picks source A or B lines.
// R5: Input term enable gates all input terminations.
// R6: Pulse bit set: disconnect ~100 ms on switch.
// R7: Pulse bit clear: termination stays connected.
// R8: Bits 0-3 A0-A3, bits 4-7 B3-B0.
// R9: Equalizer bit 0 = 6 dB, 1 = 12 dB.
// R10: Two-bit boost code shared by all outputs.
// R11: Output termination bit connects all outputs.
// R12: Drive current bit 0 = 10 mA, 1 = 20 mA.
// R13: Reset selects A, 6 dB, 0 dB, terminations on.
// R14: Low reset input restores the defaults.
// R15: Timer starts only when source select changes.
`timescale 1ns/1ps
`default_nettype none

module tmdsc_regs #(
  parameter int TERM_PULSE_LEN = tmdsc_pkg::TERM_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port, one byte per access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Static control levels
  output tmdsc_pkg::tmdsc_ctrl_t ctrl
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] high_speed_mode_r;
  logic [7:0] auxiliary_mode_r;
  logic [7:0] receiver_settings_r;
  logic [7:0] input_termination_pulse_r;
  logic [7:0] receive_equalizer_r;
  logic [7:0] transmitter_settings_r;
  // Channels held off by a running pulse
  logic [7:0] term_off_r;
  logic [7:0] term_off_nxt;
  logic [31:0] pulse_cnt_r;
  logic src_change;
  logic [7:0] rdata_nxt;
  tmdsc_pkg::tmdsc_ctrl_t ctrl_nxt;

  // Exact offset match; offsets beyond the bank decode to nothing
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // Settings to analog control levels; shared by reset and normal operation
  function automatic tmdsc_pkg::tmdsc_ctrl_t ctrl_word(
    input logic [7:0] hs,
    input logic [7:0] aux,
    input logic [7:0] rx,
    input logic [7:0] eq,
    input logic [7:0] tx,
    input logic [7:0] off
  );
    tmdsc_pkg::tmdsc_ctrl_t c;
    c.fast_path_enable = hs[tmdsc_pkg::POS_FAST_PATH_ENABLE]; // see R1
    c.fast_source_select = hs[tmdsc_pkg::POS_FAST_SOURCE_SELECT]; // see R2
    c.side_enable = aux[tmdsc_pkg::POS_SIDE_ENABLE]; // see R3
    c.side_source_select = aux[tmdsc_pkg::POS_SIDE_SOURCE_SELECT]; // see R4
    // Bit order A0..A3, B3..B0 passes straight through to the analog side
    c.input_term_connect = {8{rx[tmdsc_pkg::POS_INPUT_TERM_ENABLE]}} & ~off; // see R5 see R8
    c.input_eq_level_mask = eq; // see R9 see R8
    // Output settings are shared by all four channels
    c.output_boost_level = tx[tmdsc_pkg::POS_OUTPUT_BOOST_LEVEL +: 2]; // see R10
    c.output_term_enable = tx[tmdsc_pkg::POS_OUTPUT_TERM_ENABLE]; // see R11
    c.output_drive_current = tx[tmdsc_pkg::POS_OUTPUT_DRIVE_CURRENT]; // see R12
    return c;
  endfunction : ctrl_word

  // Pins show the defaults while reset is held, not only after it
  localparam tmdsc_pkg::tmdsc_ctrl_t CTRL_RST = ctrl_word(tmdsc_pkg::RST_HIGH_SPEED_MODE,
    tmdsc_pkg::RST_AUXILIARY_MODE, tmdsc_pkg::RST_RECEIVER_SETTINGS,
    tmdsc_pkg::RST_RECEIVE_EQUALIZER, tmdsc_pkg::RST_TRANSMITTER_SETTINGS, 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; unused bits are kept so they read back as written
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      high_speed_mode_r <= tmdsc_pkg::RST_HIGH_SPEED_MODE; // see R13 see R14
    else if (reg_wr && hit(reg_addr, tmdsc_pkg::OFF_HIGH_SPEED_MODE))
      high_speed_mode_r <= reg_wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      auxiliary_mode_r <= tmdsc_pkg::RST_AUXILIARY_MODE; // see R13
    else if (reg_wr && hit(reg_addr, tmdsc_pkg::OFF_AUXILIARY_MODE))
      auxiliary_mode_r <= reg_wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      receiver_settings_r <= tmdsc_pkg::RST_RECEIVER_SETTINGS; // see R13
    else if (reg_wr && hit(reg_addr, tmdsc_pkg::OFF_RECEIVER_SETTINGS))
      receiver_settings_r <= reg_wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      input_termination_pulse_r <= tmdsc_pkg::RST_INPUT_TERM_PULSE;
    else if (reg_wr && hit(reg_addr, tmdsc_pkg::OFF_INPUT_TERM_PULSE))
      input_termination_pulse_r <= reg_wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      receive_equalizer_r <= tmdsc_pkg::RST_RECEIVE_EQUALIZER; // see R13
    else if (reg_wr && hit(reg_addr, tmdsc_pkg::OFF_RECEIVE_EQUALIZER))
      receive_equalizer_r <= reg_wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      transmitter_settings_r <= tmdsc_pkg::RST_TRANSMITTER_SETTINGS; // see R13
    else if (reg_wr && hit(reg_addr, tmdsc_pkg::OFF_TRANSMITTER_SETTINGS))
      transmitter_settings_r <= reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Termination pulse on a source change
  // Rewriting the same source leaves the input links undisturbed
  assign src_change = reg_wr && hit(reg_addr, tmdsc_pkg::OFF_HIGH_SPEED_MODE)
    && (reg_wdata[tmdsc_pkg::POS_FAST_SOURCE_SELECT]
    != high_speed_mode_r[tmdsc_pkg::POS_FAST_SOURCE_SELECT]); // see R15

  // A new switch during a pulse restarts the full period, using the mask at that write
  always_comb
  begin
    term_off_nxt = term_off_r;
    if (src_change)
      term_off_nxt = input_termination_pulse_r; // see R6 see R7 see R15
    else if (pulse_cnt_r == 32'h0000_0001)
      term_off_nxt = 8'h00;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      term_off_r <= 8'h00;
    else
      term_off_r <= term_off_nxt;
  end

  // One timer serves every masked channel, since they all switch together
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      pulse_cnt_r <= 32'h0000_0000;
    else if (src_change)
      pulse_cnt_r <= 32'(TERM_PULSE_LEN); // see R6
    else if (pulse_cnt_r != 32'h0000_0000)
      pulse_cnt_r <= pulse_cnt_r - 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs, registered; the pins show the defaults while reset is held
  assign ctrl_nxt = ctrl_word(high_speed_mode_r, auxiliary_mode_r, receiver_settings_r, receive_equalizer_r,
    transmitter_settings_r, term_off_nxt);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      ctrl <= CTRL_RST; // see R13 see R14
    else
      ctrl <= ctrl_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read back; unmapped offsets read zero
  always_comb
  begin
    if (hit(reg_addr, tmdsc_pkg::OFF_HIGH_SPEED_MODE))
      rdata_nxt = high_speed_mode_r;
    else if (hit(reg_addr, tmdsc_pkg::OFF_AUXILIARY_MODE))
      rdata_nxt = auxiliary_mode_r;
    else if (hit(reg_addr, tmdsc_pkg::OFF_RECEIVER_SETTINGS))
      rdata_nxt = receiver_settings_r;
    else if (hit(reg_addr, tmdsc_pkg::OFF_INPUT_TERM_PULSE))
      rdata_nxt = input_termination_pulse_r;
    else if (hit(reg_addr, tmdsc_pkg::OFF_RECEIVE_EQUALIZER))
      rdata_nxt = receive_equalizer_r;
    else if (hit(reg_addr, tmdsc_pkg::OFF_TRANSMITTER_SETTINGS))
      rdata_nxt = transmitter_settings_r;
    else
      rdata_nxt = 8'h00;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      // Data holds until the next read, so a slow host may fetch it late
      if (reg_rd)
        reg_rdata <= rdata_nxt;
    end
  end

endmodule : tmdsc_regs
`default_nettype wire

/* File: rtl/tmdsc_pkg.sv */
// Package for the link switch control register bank: offsets, fields, reset values, timing.
package tmdsc_pkg;

  // Register offsets; the bank holds one byte per register
  localparam logic [7:0] OFF_HIGH_SPEED_MODE = 8'h00;
  localparam logic [7:0] OFF_AUXILIARY_MODE = 8'h01;
  localparam logic [7:0] OFF_RECEIVER_SETTINGS = 8'h02;
  localparam logic [7:0] OFF_INPUT_TERM_PULSE = 8'h03;
  localparam logic [7:0] OFF_RECEIVE_EQUALIZER = 8'h04;
  localparam logic [7:0] OFF_TRANSMITTER_SETTINGS = 8'h05;

  // Field positions
  localparam int POS_FAST_PATH_ENABLE = 0;
  localparam int POS_FAST_SOURCE_SELECT = 1;
  localparam int POS_SIDE_ENABLE = 0;
  localparam int POS_SIDE_SOURCE_SELECT = 1;
  localparam int POS_INPUT_TERM_ENABLE = 0;
  localparam int POS_OUTPUT_BOOST_LEVEL = 0;
  localparam int POS_OUTPUT_TERM_ENABLE = 2;
  localparam int POS_OUTPUT_DRIVE_CURRENT = 3;

  // Values after reset
  localparam logic [7:0] RST_HIGH_SPEED_MODE = 8'h01;
  localparam logic [7:0] RST_AUXILIARY_MODE = 8'h01;
  localparam logic [7:0] RST_RECEIVER_SETTINGS = 8'h01;
  localparam logic [7:0] RST_INPUT_TERM_PULSE = 8'h00;
  localparam logic [7:0] RST_RECEIVE_EQUALIZER = 8'h00;
  localparam logic [7:0] RST_TRANSMITTER_SETTINGS = 8'h04;

  // Termination disconnect time on a source change
  localparam int CLK_PERIOD_NS = 10;
  localparam int TERM_PULSE_MS = 100;
  localparam int TERM_PULSE_CYCLES = (TERM_PULSE_MS * 1000000) / CLK_PERIOD_NS;

  // Control levels to the analog circuits
  typedef struct packed {
    logic fast_path_enable;
    logic fast_source_select;
    logic side_enable;
    logic side_source_select;
    logic [7:0] input_term_connect;
    logic [7:0] input_eq_level_mask;
    logic [1:0] output_boost_level;
    logic output_term_enable;
    logic output_drive_current;
  } tmdsc_ctrl_t;

endpackage : tmdsc_pkg

/* File: tb/tmdsc_regs_asserts.sv */
// Port checks for the link switch control register bank.
`timescale 1ns/1ps
`default_nettype none
module tmdsc_regs_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Control levels
  input wire tmdsc_pkg::tmdsc_ctrl_t ctrl
);
  // Offset of a write, or an unused code when idle
  logic [7:0] wa;
  assign wa = reg_wr ? reg_addr : 8'hff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  a_unmapped_read: assert property (reg_rd && reg_addr > 8'h05 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_fast_enable: assert property (wa == 8'h00 ##1 !reg_wr |=> ctrl.fast_path_enable == $past(reg_wdata[0], 2))
    else $error("fast enable wrong");
  a_fast_select: assert property (wa == 8'h00 ##1 !reg_wr |=> ctrl.fast_source_select == $past(reg_wdata[1], 2))
    else $error("fast select wrong");
  a_side_enable: assert property (wa == 8'h01 ##1 !reg_wr |=> ctrl.side_enable == $past(reg_wdata[0], 2))
    else $error("side enable wrong");
  a_side_select: assert property (wa == 8'h01 ##1 !reg_wr |=> ctrl.side_source_select == $past(reg_wdata[1], 2))
    else $error("side select wrong");
  a_input_term_off: assert property (wa == 8'h02 && !reg_wdata[0] ##1 !reg_wr |=> ctrl.input_term_connect == 8'h00)
    else $error("input term not off");
  a_eq_level: assert property (wa == 8'h04 ##1 !reg_wr |=> ctrl.input_eq_level_mask == $past(reg_wdata, 2))
    else $error("eq mask wrong");
  a_output_setup: assert property (wa == 8'h05 ##1 !reg_wr |=>
    {ctrl.output_drive_current, ctrl.output_term_enable, ctrl.output_boost_level} == $past(reg_wdata[3:0], 2))
    else $error("output settings wrong");
endmodule : tmdsc_regs_asserts
`default_nettype wire

/* File: tb/tmdsc_host.sv */
// Host controller model driving the register port.
`timescale 1ns/1ps
`default_nettype none
module tmdsc_host (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge ref_clk);
    #1;
    // Stale data must not look valid
    {reg_wr, reg_wdata} = {1'b0, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(posedge ref_clk);
    #1;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (reg_rvalid)
      begin
        d = reg_rdata;
        break;
      end
      @(posedge ref_clk);
      #1;
    end
  endtask : rd
endmodule : tmdsc_host
`default_nettype wire

/* File: tb/tb_tmdsc_regs.sv */
// Self-checking bench for the link switch control register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD %0t got %h want %h", $time, got, exp); end end
module tb_tmdsc_regs;
  // Short pulse keeps the run brief
  localparam int PL = 20;
  logic ref_clk, rstn, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [31:0] lfsr = 32'he6c83679;
  logic [7:0] sh [6];
  int n_errors = 0;
  int num_checks = 0;
  int k;
  tmdsc_pkg::tmdsc_ctrl_t ctrl;
  tmdsc_regs #(.TERM_PULSE_LEN(PL)) tmdsc_regs_i (.ref_clk(ref_clk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .ctrl(ctrl));
  tmdsc_host tmdsc_host_i (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd
  // Pt holds the channels held off by a running pulse
  function automatic tmdsc_pkg::tmdsc_ctrl_t exp_ctrl(input logic [7:0] pt);
    return '{sh[0][0], sh[0][1], sh[1][0], sh[1][1], sh[2][0] ? ~pt : 8'h00, sh[4], sh[5][1:0], sh[5][2], sh[5][3]};
  endfunction : exp_ctrl
  task automatic put(input int a, input logic [7:0] d, input logic [7:0] pt);
    tmdsc_host_i.wr(8'(a), d);
    sh[a] = d;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(ctrl, exp_ctrl(pt))
  endtask : put
  task automatic do_reset();
    rstn = 1'b0;
    sh = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h04};
    repeat (4) @(posedge ref_clk);
    #1;
    // Defaults must already stand while reset is held
    `CHK(ctrl, exp_ctrl(8'h00))
    rstn = 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK(ctrl, exp_ctrl(8'h00))
    for (int a = 0; a < 7; a++)
    begin
      tmdsc_host_i.rd(8'(a), rv);
      `CHK(rv, a < 6 ? sh[a] : 8'h00)
    end
  endtask : do_reset
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #1000000;
    n_errors++;
    finish_test();
  end
  initial
  begin
    do_reset();
    put(3, 8'h5a, 8'h00);
    put(0, 8'h03, 8'h5a);
    repeat (PL - 4) @(posedge ref_clk);
    #1;
    `CHK(ctrl, exp_ctrl(8'h5a))
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK(ctrl, exp_ctrl(8'h00))
    put(0, 8'h03, 8'h00);
    for (int c = 0; c < 4; c++)
      put(5, 8'(c) | 8'h0c, 8'h00);
    for (int i = 0; i < 40; i++)
    begin
      k = rnd() % 6;
      rv = rnd();
      // Same source keeps pulses out of the random part
      if (k == 0)
        rv[1] = sh[0][1];
      put(k, rv, 8'h00);
      tmdsc_host_i.rd(8'(k), rv);
      `CHK(rv, sh[k])
    end
    // Reset lands in the middle of a running pulse
    put(0, {6'h00, ~sh[0][1], 1'b1}, sh[3]);
    do_reset();
    finish_test();
  end
endmodule : tb_tmdsc_regs
bind tmdsc_regs tmdsc_regs_asserts tmdsc_regs_asserts_i (.ref_clk(ref_clk), .rstn(rstn), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .ctrl(ctrl));
`default_nettype wire
